/* prc_top.v */
// Purpose: performance report control register with its effects
// Assumes: loss and AIS inputs come from pins, synchronised here
// Notes: build-out setting itself is held outside
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ns
`include "prc_consts.vh"
module prc_top #(
   parameter SEC_CYC = `PRC_SEC_CYC
) (
   // clock and reset
   input wire clk_i,
   input wire srst_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // line side
   input wire tx_ais_i,
   input wire short_haul_i,
   input wire [4:0] line_buildout_setting_i,
   input wire rx_loss_i,
   input wire report_done_i,
   output reg [4:0] line_buildout_eff_o,
   output reg rx_loss_signal_pin_o,
   output reg rx_loss_signal_pin_oe_o,
   output reg report_req_o,
   output reg report_cr_o
);

   // ==================================================
   // internal state
   localparam NPIN = 2;
   localparam PIN_AIS = 0;
   localparam PIN_LOS = 1;

   reg [7:0] ctrl_r;
   reg [7:0] ctrl_nxt;
   reg [31:0] rd_nxt;
   reg [4:0] buildout_nxt;
   reg [1:0] prev_sel_r;
   reg req_nxt;
   reg cr_nxt;
   reg [7:0] sent_r;
   reg [7:0] sent_nxt;
   wire [NPIN-1:0] pin_raw;
   wire [NPIN-1:0] pin_clean;
   wire sec_tick;
   wire sec_fire;
   wire [1:0] sel;
   wire acc;
   wire wr_ctrl;
   wire step_on;
   wire once_edge;
   wire sel_quiet;

   assign sel = ctrl_r[1:0];
   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl = acc && wb_we_i && wb_sel_i[0] &&
      (wb_adr_i == `PRC_ADDR_CTRL);
   assign pin_raw = {rx_loss_i, tx_ais_i};

   // ==================================================
   // pin synchronisers: change counts when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
         reg [2:0] stage_r;
         reg clean_r;
         always @(posedge clk_i) begin
            if (srst_i) begin
               stage_r <= 3'h0;
               clean_r <= 1'b0;
            end else begin
               stage_r <= {stage_r[1:0], pin_raw[gi]};
               if (stage_r[1] == stage_r[2]) begin
                  clean_r <= stage_r[2];
               end
            end
         end
         assign pin_clean[gi] = clean_r;
      end
   endgenerate

   // ==================================================
   // once-per-second timer
   prc_tick #(.PERIOD(SEC_CYC)) u_tick (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .run_i(sel == `PRC_SEL_SEC),
      .tick_o(sec_tick)
   );

   // tick is registered, so it can trail a mode change by one cycle
   assign sec_fire = sec_tick && (sel == `PRC_SEL_SEC);

   // ==================================================
   // bus slave
   always @* begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = wb_dat_i[7:0] & `PRC_CTRL_MASK; // [RULE9]
      end
   end

   always @* begin
      rd_nxt = wb_dat_o;
      if (acc) begin
         case (wb_adr_i)
            `PRC_ADDR_CTRL: begin
               rd_nxt = {24'h000000, ctrl_r};
            end
            `PRC_ADDR_STAT: begin
               rd_nxt = {24'h000000, sent_r};
            end
            default: begin
               rd_nxt = 32'h00000000;
            end
         endcase
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_r <= `PRC_CTRL_RESET; // [RULE3] [RULE4] [RULE6]
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         ctrl_r <= ctrl_nxt;
         wb_ack_o <= acc;
         wb_dat_o <= rd_nxt;
      end
   end

   // ==================================================
   // line outputs
   // setting 0 is lowest, so no step below it
   assign step_on = ctrl_r[`PRC_BIT_STEP] && pin_clean[PIN_AIS] &&
      short_haul_i && (line_buildout_setting_i != 5'h00);

   always @* begin
      if (step_on) begin // [RULE1] [RULE2]
         buildout_nxt = line_buildout_setting_i - 5'h01;
      end else begin
         buildout_nxt = line_buildout_setting_i;
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         line_buildout_eff_o <= 5'h00;
         rx_loss_signal_pin_o <= 1'b1;
         rx_loss_signal_pin_oe_o <= 1'b0;
      end else begin
         line_buildout_eff_o <= buildout_nxt;
         rx_loss_signal_pin_o <= !pin_clean[PIN_LOS];
         rx_loss_signal_pin_oe_o <= ctrl_r[`PRC_BIT_LOSEN]; // [RULE3]
      end
   end

   // ==================================================
   // report requests, held until the report engine accepts or the field goes to 00 or 11
   assign once_edge = (prev_sel_r == `PRC_SEL_NONE) &&
      (sel == `PRC_SEL_ONCE);
   assign sel_quiet = (sel == `PRC_SEL_NONE) || (sel == `PRC_SEL_OFF);

   always @* begin
      req_nxt = report_req_o;
      cr_nxt = report_cr_o;
      if (once_edge || sec_fire) begin // [RULE5] [RULE7] [RULE8]
         req_nxt = 1'b1;
         cr_nxt = ctrl_r[`PRC_BIT_CR]; // [RULE4]
      end else if (report_done_i) begin
         req_nxt = 1'b0;
      end else if (sel_quiet) begin
         req_nxt = 1'b0; // [RULE6]
      end
   end

   // a done that meets a new trigger still counts
   always @* begin
      sent_nxt = sent_r;
      if (report_done_i && report_req_o) begin
         sent_nxt = sent_r + 8'h01;
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         prev_sel_r <= `PRC_SEL_NONE;
         report_req_o <= 1'b0;
         report_cr_o <= 1'b0;
         sent_r <= 8'h00;
      end else begin
         prev_sel_r <= sel;
         report_req_o <= req_nxt;
         report_cr_o <= cr_nxt;
         sent_r <= sent_nxt;
      end
   end

endmodule // prc_top

/* prc_consts.vh */
// Purpose: constants for the performance report control block
// Assumes: 25 MHz clock, classic Wishbone register access
// Notes: what this block does is listed below
// What this block does
// (RULE1) auto-step lowers build-out one setting during AIS
// (RULE2) step applies only in T1 short haul
// (RULE3) loss pin enable gates pin, resets 1
// (RULE4) C/R flag copied into reports, resets 0
// (RULE5) report field controls summary report insertion
// (RULE6) field 00 or 11 issues no report
// (RULE7) one report on 00 to 01 change
// (RULE8) field 10 reports once every second
// (RULE9) bits five to three read zero
`ifndef PRC_CONSTS_VH
`define PRC_CONSTS_VH
// ==================================================
// register map
`define PRC_ADDR_CTRL 4'h0
`define PRC_ADDR_STAT 4'h4
`define PRC_CTRL_RESET 8'h40
`define PRC_CTRL_MASK 8'hC7
`define PRC_BIT_STEP 7
`define PRC_BIT_LOSEN 6
`define PRC_BIT_CR 2
`define PRC_SEL_NONE 2'h0
`define PRC_SEL_ONCE 2'h1
`define PRC_SEL_SEC 2'h2
`define PRC_SEL_OFF 2'h3
// ==================================================
// timing
`define PRC_CLK_HZ 25000000
`define PRC_SEC_NS 1000000000
`define PRC_SEC_CYC (`PRC_CLK_HZ / 1000000 * (`PRC_SEC_NS / 1000))
`endif

/* prc_tick.v */
// Purpose: one-cycle tick every period of cycles
// Assumes: synchronous active-high reset
// Notes: restarts whenever run is low
`timescale 1ns/1ns
module prc_tick #(
   parameter PERIOD = 25000000
) (
   input wire clk_i,
   input wire srst_i,
   input wire run_i,
   output reg tick_o
);
   reg [31:0] cnt_r;
   always @(posedge clk_i) begin
      if (srst_i || !run_i) begin
         cnt_r <= 32'h0;
         tick_o <= 1'b0;
      end else if (cnt_r == PERIOD - 1) begin
         cnt_r <= 32'h0;
         tick_o <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         tick_o <= 1'b0;
      end
   end
endmodule // prc_tick

/* prc_sink.sv */
// Purpose: report engine model taking report requests
// Assumes: done is a one-cycle pulse
// Notes: slow_i stretches the wait to stress request holding
`timescale 1ns/1ns
module prc_sink(input wire clk_i,srst_i,req_i,slow_i,output reg done_o);
reg [2:0] w_r;
always @(posedge clk_i) begin
   done_o <= 1'b0;
   if (srst_i || !req_i || done_o) begin
      w_r <= 3'h0;
   end else if (w_r == (slow_i ? 3'h4 : 3'h0)) begin
      done_o <= 1'b1;
   end else begin
      w_r <= w_r + 3'h1;
   end
end
endmodule // prc_sink

/* prc_chk_assertions.sv */
// Purpose: port checks of prc_top
// Assumes: synchronous active-high reset
// Notes: bound at the foot
`timescale 1ns/1ns
module prc_chk(input wire clk_i,srst_i,wb_cyc_i,wb_stb_i,wb_ack_o,
   short_haul_i,report_req_o,report_done_i,report_cr_o,
   rx_loss_signal_pin_oe_o,input wire [4:0] line_buildout_setting_i,
   line_buildout_eff_o);
default clocking @(posedge clk_i); endclocking
default disable iff (srst_i);
property p_ack; wb_cyc_i&&wb_stb_i&&!wb_ack_o |=> wb_ack_o; endproperty
property p_one; wb_ack_o |=> !wb_ack_o; endproperty
property p_idle; !wb_stb_i |=> !wb_ack_o; endproperty
property p_hold; report_req_o&&!report_done_i&&!wb_ack_o |=> report_req_o;
endproperty
property p_cr; $changed(report_cr_o) |-> report_req_o; endproperty
property p_oe; !$past(srst_i,2)&&$changed(rx_loss_signal_pin_oe_o)
   |-> wb_ack_o||$past(wb_ack_o); endproperty
property p_bo; !$past(srst_i) |->
   line_buildout_eff_o<=$past(line_buildout_setting_i); endproperty
property p_sh; !$past(srst_i)&&!$past(short_haul_i) |->
   line_buildout_eff_o==$past(line_buildout_setting_i); endproperty
a_ack: assert property(p_ack) else $error("no ack");
a_one: assert property(p_one) else $error("long ack");
a_idle: assert property(p_idle) else $error("stray ack");
a_hold: assert property(p_hold) else $error("request lost");
a_cr: assert property(p_cr) else $error("flag moved");
a_oe: assert property(p_oe) else $error("pin enable moved");
a_bo: assert property(p_bo) else $error("build-out up");
a_sh: assert property(p_sh) else $error("build-out stepped");
c_req: cover property(report_req_o&&report_done_i);
c_stp: cover property(line_buildout_eff_o!=line_buildout_setting_i);
c_oe: cover property($fell(rx_loss_signal_pin_oe_o));
endmodule // prc_chk
bind prc_top prc_chk u_chk(.*);

/* testbench.sv */
// Purpose: self-checking bench for prc_top
// Assumes: one-second period shortened to 20 cycles
// Notes: status register counts accepted reports
`timescale 1ns/1ns
`define CHK(a,b) begin n_compared++; if((a)!==(b)) begin miscompares++;\
$display("[FAIL] %0t %h %h",$time,a,b); end end
module testbench;
reg clk_i=0,srst_i=1,cyc=0,we=0,ais=0,sh=0,slow=0,los=0;
reg [3:0] adr=0; reg [31:0] wd=0,rd=0,seed=97; reg [4:0] bo=0;
reg [7:0] c0; integer miscompares=0,n_compared=0,i;
wire ack,req,done,cr,oe,pin; wire [31:0] dat; wire [4:0] eff;
prc_top #(.SEC_CYC(20)) uut(.clk_i(clk_i),.srst_i(srst_i),.wb_cyc_i(cyc),
.wb_stb_i(cyc),.wb_we_i(we),.wb_adr_i(adr),.wb_sel_i(4'hF),.wb_dat_i(wd),
.wb_dat_o(dat),.wb_ack_o(ack),.tx_ais_i(ais),.short_haul_i(sh),
.line_buildout_setting_i(bo),.rx_loss_i(los),.report_done_i(done),
.line_buildout_eff_o(eff),.rx_loss_signal_pin_o(pin),
.rx_loss_signal_pin_oe_o(oe),.report_req_o(req),.report_cr_o(cr));
prc_sink sink(.clk_i(clk_i),.srst_i(srst_i),.req_i(req),.slow_i(slow),
.done_o(done));
initial forever #20 clk_i = ~clk_i;
function [31:0] xs(input [31:0] v); begin
   v = v^(v<<13); v = v^(v>>17); xs = v^(v<<5); end endfunction
task wb(input w,input [3:0] a,input [7:0] d); begin
   @(posedge clk_i); cyc <= 1; we <= w; adr <= a; wd <= {24'h0,d};
   do @(posedge clk_i); while (ack !== 1'b1);
   rd = dat; cyc <= 0; end endtask
task summarize; begin
   $display("compared %0d miscompares %0d",n_compared,miscompares);
   if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
   else $display("TB: FAIL");
   $finish; end endtask
initial begin #200000; miscompares++; summarize; end
initial begin
   repeat (16) @(posedge clk_i); srst_i <= 0;
   wb(0,0,0); `CHK(rd[7:0],8'h40)
   wb(1,0,8'hFF); wb(0,0,0); `CHK(rd[7:0],8'hC7)
   wb(1,0,8'h00); repeat (2) @(negedge clk_i); `CHK(oe,1'b0)
   for (i = 0; i < 4; i++) begin
      @(posedge clk_i); seed = xs(seed); los <= seed[2];
      slow <= seed[1]; bo <= seed[8:4]|5'h01;
      sh <= 1; ais <= 1; wb(1,0,8'h80); repeat (8) @(negedge clk_i);
      `CHK(eff,bo-5'h01)
      `CHK(pin,~los)
      @(posedge clk_i); sh <= 0; repeat (4) @(negedge clk_i);
      `CHK(eff,bo)
   end
   $display("build-out test done"); @(posedge clk_i); ais <= 0;
   wb(1,0,8'h04); wb(0,4,0); c0 = rd[7:0];
   wb(1,0,8'h05); repeat (40) @(negedge clk_i); wb(0,4,0);
   `CHK(rd[7:0],c0+8'h01)
   `CHK(cr,1'b1)
   wb(1,0,8'h05); repeat (40) @(negedge clk_i); wb(0,4,0);
   `CHK(rd[7:0],c0+8'h01)
   wb(1,0,8'h02); repeat (112) @(negedge clk_i); wb(1,0,8'h03); wb(0,4,0);
   `CHK(rd[7:0],c0+8'h06)
   repeat (60) @(negedge clk_i); wb(0,4,0);
   `CHK(rd[7:0],c0+8'h06)
   $display("report test done"); summarize;
end
endmodule // testbench
